// *** pipelined_sync_burst_sram_read_tb_top.sv ***
// Bench of the burst memory: writes, reads, bursts, deselect, sleep, scan.
// Assumes sbs_sram with a four-bit address and the host model on its lines.
`timescale 1ns/1ns
module pipelined_sync_burst_sram_read_tb_top;
  localparam logic [35:0] W_A = 36'h9a5a5a5a5;
  localparam logic [35:0] W_B = 36'h63c3c3c3c;
  localparam logic [35:0] M = 36'h500ff00ff;
  localparam logic [35:0] W_M = (W_B & M) | (W_A & ~M);
  localparam logic [35:0] W = 36'h111111111;
  logic mclk_in = 1'b0, rstn_in = 1'b0, order = 1'b0, sleep = 1'b0;
  logic pa_n = 1'b1, ca_n = 1'b1, prim_n = 1'b0, sel_hi = 1'b1, third_n = 1'b0;
  logic glob_n = 1'b1, bytg_n = 1'b1, step_n = 1'b1, oe_n = 1'b1, host_oe = 1'b0;
  logic tck = 1'b0, tdi = 1'b0, tms = 1'b0, ready, d_oe, p_oe, tdo, tdo_oe;
  logic [3:0] addr = 4'h0, lane_n = 4'hf, p_out;
  logic [31:0] d_out;
  logic [35:0] host_w = 36'h0, bus, word;
  int errors = 0, tests_run = 0;
  assign word = {p_out, d_out};
  always #25 mclk_in = ~mclk_in;
  sbs_sram #(.ADDR_W(4)) dut_u (.mclk_in(mclk_in), .rstn_in(rstn_in), .addr_in(addr),
    .processor_address_strobe_n_in(pa_n), .controller_address_strobe_n_in(ca_n),
    .burst_step_n_in(step_n), .chip_select_primary_n_in(prim_n), .chip_select_high_in(sel_hi),
    .chip_select_third_n_in(third_n), .global_write_n_in(glob_n), .byte_write_gate_n_in(bytg_n),
    .byte_lane_select_n_in(lane_n), .output_enable_n_in(oe_n), .sleep_request_in(sleep),
    .burst_order_in(order), .accept_ready_out(ready), .data_in(bus[31:0]),
    .parity_lines_in(bus[35:32]), .data_out(d_out), .parity_lines_out(p_out),
    .data_oe_out(d_oe), .parity_lines_oe_out(p_oe), .test_clk_in(tck), .test_data_in(tdi),
    .test_mode_select_in(tms), .test_data_out(tdo), .test_data_oe_out(tdo_oe));
  sbs_host_model host_u (.mclk_in(mclk_in), .dev_word_in(word), .dev_oe_in(d_oe),
    .host_word_in(host_w), .host_oe_in(host_oe), .bus_out(bus));
  task automatic end_of_test();
    $display("checks %0d errors %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input string what, input logic [35:0] exp, input logic [35:0] got);
    tests_run++;
    if (got !== exp)
    begin
      errors++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(negedge mclk_in);
  endtask
  task automatic st(input logic [7:0] c);
    {pa_n, ca_n, prim_n, sel_hi, third_n, glob_n, bytg_n, step_n} = c;
  endtask
  task automatic rst(input logic mode);
    int i;
    order = mode;
    rstn_in = 1'b0;
    tick(16);
    chk("reset outputs", 36'h0, {34'h0, ready, d_oe});
    rstn_in = 1'b1;
    for (i = 0; i < 8 && ready !== 1'b1; i++)
      tick(1);
    chk("ready", 36'h1, {35'h0, ready});
    if (ready !== 1'b1)
      end_of_test();
  endtask
  // The device must stop driving one edge before the host drives, or the device word wins on the lines.
  task automatic wr(input logic [3:0] a, input logic [35:0] w, input logic [7:0] c,
    input logic [3:0] ln);
    oe_n = 1'b1;
    tick(1);
    st(c);
    addr = a;
    lane_n = ln;
    host_w = w;
    host_oe = 1'b1;
    tick(1);
    st(8'hd7);
    host_oe = 1'b0;
    lane_n = 4'hf;
    tick(4);
  endtask
  task automatic rd(input logic [3:0] a, input logic [35:0] e);
    oe_n = 1'b0;
    st(8'h97);
    addr = a;
    tick(1);
    st(8'hd7);
    tick(1);
    chk("read word", e, word);
    chk("read drive", 36'h3, {34'h0, p_oe, d_oe});
  endtask
  task automatic t_lanes();
    wr(4'h1, W_A, 8'h91, 4'ha);
    wr(4'h1, W_B, 8'h95, 4'ha);
    rd(4'h1, W_M);
  endtask
  task automatic t_b2b();
    wr(4'h2, W_A, 8'h93, 4'hf);
    oe_n = 1'b0;
    st(8'h97);
    addr = 4'h1;
    tick(1);
    addr = 4'h2;
    tick(1);
    chk("first of pair", W_M, word);
    st(8'hd7);
    tick(1);
    chk("second of pair", W_A, word);
  endtask
  task automatic t_desel();
    rd(4'h1, W_M);
    st(8'h77);
    tick(1);
    st(8'hd7);
    tick(1);
    chk("ignored strobe", 36'h1, {35'h0, d_oe});
    st(8'h87);
    tick(1);
    chk("deselect drive", 36'h0, {35'h0, d_oe});
    st(8'h97);
    tick(1);
    chk("first cycle drive", 36'h0, {35'h0, d_oe});
    st(8'hd7);
    tick(1);
    chk("after first cycle", W_M, word);
    st(8'h13);
    tick(1);
    st(8'hd7);
    tick(1);
    chk("both strobes", W_M, word);
    chk("both strobes drive", 36'h1, {35'h0, d_oe});
  endtask
  task automatic t_sleep();
    oe_n = 1'b1;
    tick(1);
    chk("enable high drive", 36'h0, {35'h0, d_oe});
    oe_n = 1'b0;
    sleep = 1'b1;
    tick(2);
    chk("sleep outputs", 36'h0, {34'h0, ready, d_oe});
    sleep = 1'b0;
    tick(3);
    rd(4'h1, W_M);
  endtask
  task automatic t_scan();
    int i;
    for (i = 0; i < 2; i++)
    begin
      tdi = ~i[0];
      tms = i[0];
      tick(2);
      tck = 1'b1;
      tick(4);
      chk("scan out before fall", {35'h0, i[0]}, {35'h0, tdo});
      tdi = i[0];
      tms = ~i[0];
      tck = 1'b0;
      tick(4);
      chk("scan out", {34'h0, ~i[0], ~i[0]}, {34'h0, tdo_oe, tdo});
    end
  endtask
  task automatic t_burst(input logic mode);
    int k;
    logic [3:0] a;
    rst(mode);
    for (k = 4; k < 8; k++)
      wr(k[3:0], W * k[3:0], 8'h93, 4'hf);
    oe_n = 1'b0;
    st(8'h97);
    addr = 4'h5;
    tick(1);
    st(8'hd6);
    for (k = 0; k < 4; k++)
    begin
      tick(1);
      a = (mode == sbs_pkg::MODE_INTERLEAVED) ? {2'h1, 2'h1 ^ k[1:0]} : {2'h1, 2'h1 + k[1:0]};
      chk("burst word", W * a, word);
    end
    st(8'hd7);
  endtask
  initial
  begin
    #2000000;
    errors++;
    end_of_test();
  end
  initial
  begin
    rst(sbs_pkg::MODE_LINEAR);
    t_lanes();
    t_b2b();
    t_desel();
    t_sleep();
    t_scan();
    t_burst(sbs_pkg::MODE_LINEAR);
    t_burst(sbs_pkg::MODE_INTERLEAVED);
    end_of_test();
  end
endmodule

// *** sbs_buffer.sv ***
// Small first-in first-out buffer with valid and ready on both sides.
// Assumes the parent clocks it from the same clock and synchronous reset.
`timescale 1ns/1ns
module sbs_buffer #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 2
) (
  // Clock and reset
  input wire logic mclk_in,
  input wire logic rstn_in,
  // Filling side
  input wire logic in_valid_in,
  input wire logic [WIDTH-1:0] in_data_in,
  output logic in_ready_out,
  // Draining side
  output logic out_valid_out,
  output logic [WIDTH-1:0] out_data_out,
  input wire logic out_ready_in
);

  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] slot;
    logic [PW-1:0] rd;
    logic [PW-1:0] wr;
    logic [CW-1:0] cnt;
  } sbs_buf_state_t;

  sbs_buf_state_t r;
  sbs_buf_state_t next_r;
  logic push;
  logic pop;

  function automatic logic [PW-1:0] advance(input logic [PW-1:0] p);
    if (p == PW'(DEPTH - 1))
      return '0;
    return PW'(p + PW'(1));
  endfunction

  always_comb
  begin
    next_r = r;
    push = in_valid_in && (r.cnt != CW'(DEPTH));
    pop = out_ready_in && (r.cnt != '0);
    if (push)
    begin
      next_r.slot[r.wr] = in_data_in;
      next_r.wr = advance(r.wr);
    end
    if (pop)
      next_r.rd = advance(r.rd);
    if (push && !pop)
      next_r.cnt = CW'(r.cnt + CW'(1));
    else if (pop && !push)
      next_r.cnt = CW'(r.cnt - CW'(1));
  end

  always_ff @(posedge mclk_in)
  begin
    if (!rstn_in)
      r <= '0;
    else
      r <= next_r;
  end

  assign in_ready_out = (r.cnt != CW'(DEPTH));
  assign out_valid_out = (r.cnt != '0);
  assign out_data_out = r.slot[r.rd];

endmodule

// *** sbs_host_model.sv ***
// Far-side model: resolves the shared data and parity lines.
// Assumes the bench supplies the host word and its drive enable.
`timescale 1ns/1ns
module sbs_host_model (
  // Clock
  input wire logic mclk_in,
  // Device side
  input wire logic [35:0] dev_word_in,
  input wire logic dev_oe_in,
  // Host side
  input wire logic [35:0] host_word_in,
  input wire logic host_oe_in,
  // Resolved lines
  output logic [35:0] bus_out
);
  logic [35:0] last = 36'h0;
  // Undriven lines show the inverse of the last level, so they flip every edge and stale data passes every other cycle.
  always_comb
    if (dev_oe_in)
      bus_out = dev_word_in;
    else if (host_oe_in)
      bus_out = host_word_in;
    else
      bus_out = ~last;
  always @(posedge mclk_in)
    last <= bus_out;
endmodule

// *** sbs_pkg.sv ***
// Shared constants of the pipelined synchronous burst memory block.
// Assumes one rising-edge clock and a synchronous active-low reset.
package sbs_pkg;

  // Word layout: four byte lanes, each eight data bits and one parity bit.
  localparam int LANES = 4;
  localparam int BYTE_W = 8;
  localparam int LANE_W = 9;
  localparam int DATA_W = 32;
  localparam int WORD_W = 36;
  localparam int LANE_PARITY_BIT = 8;

  // Lane masks.
  localparam logic [3:0] ALL_LANES = 4'hf;
  localparam logic [3:0] NO_LANES = 4'h0;

  // Burst counter start and step.
  localparam logic [1:0] BURST_FIRST = 2'h0;
  localparam logic [1:0] BURST_STEP = 2'h1;

  // Burst order strap values.
  localparam logic MODE_LINEAR = 1'b0;
  localparam logic MODE_INTERLEAVED = 1'b1;

  // Reset values of sampled active-low controls: idle means high.
  localparam logic CTRL_IDLE_N = 1'b1;
  localparam logic [3:0] LANE_IDLE_N = 4'hf;

  // Depth of the write buffer in front of the array.
  localparam int WBUF_DEPTH = 2;

endpackage

// *** sbs_sram.sv ***
// Pipelined synchronous burst memory: registered pins, burst counter,
// byte-lane writes through a small write buffer, and a bypass scan path.
// Assumes all pins, the scan clock included, are synchronous to mclk_in.
`timescale 1ns/1ns
module sbs_sram #(
  parameter int ADDR_W = 4
) (
  // Clock and reset
  input wire logic mclk_in,
  input wire logic rstn_in,
  // Address and access control
  input wire logic [ADDR_W-1:0] addr_in,
  input wire logic processor_address_strobe_n_in,
  input wire logic controller_address_strobe_n_in,
  input wire logic burst_step_n_in,
  input wire logic chip_select_primary_n_in,
  input wire logic chip_select_high_in,
  input wire logic chip_select_third_n_in,
  input wire logic global_write_n_in,
  input wire logic byte_write_gate_n_in,
  input wire logic [3:0] byte_lane_select_n_in,
  input wire logic output_enable_n_in,
  input wire logic sleep_request_in,
  input wire logic burst_order_in,
  output logic accept_ready_out,
  // Data and parity lines
  input wire logic [31:0] data_in,
  input wire logic [3:0] parity_lines_in,
  output logic [31:0] data_out,
  output logic [3:0] parity_lines_out,
  output logic data_oe_out,
  output logic parity_lines_oe_out,
  // Boundary scan
  input wire logic test_clk_in,
  input wire logic test_data_in,
  input wire logic test_mode_select_in,
  output logic test_data_out,
  output logic test_data_oe_out
);

  localparam int DEPTH = 2 ** ADDR_W;
  localparam int ENTRY_W = ADDR_W + sbs_pkg::LANES + sbs_pkg::WORD_W;

  typedef struct packed {
    // Input register stage.
    logic [ADDR_W-1:0] a;
    logic processor_address_strobe_n;
    logic controller_address_strobe_n;
    logic adv_n;
    logic ce1_n;
    logic ce2;
    logic ce3_n;
    logic gw_n;
    logic bwe_n;
    logic [3:0] bw_n;
    logic [sbs_pkg::WORD_W-1:0] dq;
    logic zz;
    // Access state.
    logic mode;
    logic mode_taken;
    logic active;
    logic [ADDR_W-1:0] addr;
    logic [1:0] cnt;
    logic have_data;
    // Output register stage.
    logic [31:0] dout;
    logic [3:0] pout;
    logic oe;
    logic ready;
    // Array.
    logic [DEPTH-1:0][sbs_pkg::WORD_W-1:0] mem;
    // Scan path.
    logic tck;
    logic tdi_cap;
    logic tms_cap;
    logic tdo;
    logic tdo_oe;
  } sbs_state_t;

  sbs_state_t r;
  sbs_state_t next_r;

  logic buf_in_ready;
  logic buf_out_valid;
  logic [ENTRY_W-1:0] buf_out_data;
  logic push_valid;
  logic [ENTRY_W-1:0] push_data;
  logic pop_ready;

  function automatic logic starts_access(input logic processor_address_strobe_n, input logic controller_address_strobe_n,
                                         input logic ce1_n);
    // The processor strobe only counts with the primary select low.
    return (!processor_address_strobe_n && !ce1_n) || !controller_address_strobe_n;
  endfunction

  function automatic logic is_selected(input logic ce1_n, input logic ce2,
                                       input logic ce3_n);
    return !ce1_n && ce2 && !ce3_n;
  endfunction

  function automatic logic [1:0] burst_offset(input logic [1:0] first,
                                              input logic [1:0] cnt,
                                              input logic mode);
    if (mode == sbs_pkg::MODE_INTERLEAVED)
      return first ^ cnt;
    return 2'(first + cnt);
  endfunction

  // Gate low with every lane select high is still a write cycle: nothing
  // lands in the array, but the drivers stay off as for any write.
  function automatic logic write_request(input logic gw_n, input logic bwe_n);
    return !gw_n || !bwe_n;
  endfunction

  function automatic logic [3:0] lane_mask(input logic gw_n, input logic bwe_n,
                                           input logic [3:0] bw_n);
    if (!gw_n)
      return sbs_pkg::ALL_LANES;
    if (!bwe_n)
      return ~bw_n;
    return sbs_pkg::NO_LANES;
  endfunction

  always_comb
  begin
    logic start;
    logic start_p;
    logic selected;
    logic write_now;
    logic read_now;
    logic deselect;
    logic raw_deselect;
    logic [ADDR_W-1:0] base;
    logic [ADDR_W-1:0] eff;
    logic [1:0] cnt_eff;
    logic [ADDR_W-1:0] pop_addr;
    logic [3:0] pop_lanes;
    logic [sbs_pkg::WORD_W-1:0] pop_word;
    start = 1'b0;
    start_p = 1'b0;
    selected = 1'b0;
    write_now = 1'b0;
    read_now = 1'b0;
    deselect = 1'b0;
    raw_deselect = 1'b0;
    base = r.addr;
    cnt_eff = r.cnt;
    eff = r.addr;
    pop_addr = buf_out_data[ENTRY_W-1 -: ADDR_W];
    pop_lanes = buf_out_data[sbs_pkg::WORD_W +: sbs_pkg::LANES];
    pop_word = buf_out_data[sbs_pkg::WORD_W-1:0];
    next_r = r;

    // Address, control, lane, sleep and data pins are taken into the input register first.
    next_r.a = addr_in;
    next_r.processor_address_strobe_n = processor_address_strobe_n_in;
    next_r.controller_address_strobe_n = controller_address_strobe_n_in;
    next_r.adv_n = burst_step_n_in;
    next_r.ce1_n = chip_select_primary_n_in;
    next_r.ce2 = chip_select_high_in;
    next_r.ce3_n = chip_select_third_n_in;
    next_r.gw_n = global_write_n_in;
    next_r.bwe_n = byte_write_gate_n_in;
    next_r.bw_n = byte_lane_select_n_in;
    next_r.zz = sleep_request_in;
    for (int i = 0; i < sbs_pkg::LANES; i++)
    begin
      next_r.dq[i*sbs_pkg::LANE_W +: sbs_pkg::BYTE_W] = data_in[i*sbs_pkg::BYTE_W +: 8];
      next_r.dq[i*sbs_pkg::LANE_W + sbs_pkg::LANE_PARITY_BIT] = parity_lines_in[i];
    end

    // The strap is caught once after reset; later changes are ignored.
    if (!r.mode_taken)
    begin
      next_r.mode = burst_order_in;
      next_r.mode_taken = 1'b1;
    end

    // Decoding works on the input register stage, one edge behind the pins.
    start_p = !r.processor_address_strobe_n && !r.ce1_n;
    start = starts_access(r.processor_address_strobe_n, r.controller_address_strobe_n, r.ce1_n);
    selected = is_selected(r.ce1_n, r.ce2, r.ce3_n);

    // Sleep freezes access decoding; the array keeps its contents.
    if (!r.zz)
    begin
      if (start)
      begin
        if (selected)
        begin
          next_r.active = 1'b1;
          base = r.a;
          cnt_eff = sbs_pkg::BURST_FIRST;
          next_r.addr = r.a;
          // A processor-strobe start ignores the write inputs in its first cycle.
          write_now = !start_p && write_request(r.gw_n, r.bwe_n);
          read_now = !write_now;
        end
        else
        begin
          next_r.active = 1'b0;
          deselect = 1'b1;
        end
      end
      else if (r.active)
      begin
        if (!r.adv_n)
          cnt_eff = 2'(r.cnt + sbs_pkg::BURST_STEP);
        write_now = write_request(r.gw_n, r.bwe_n);
        read_now = !write_now;
      end
    end
    next_r.cnt = cnt_eff;
    eff = {base[ADDR_W-1:2], burst_offset(base[1:0], cnt_eff, r.mode)};

    // Writes queue behind the buffer so a sleep stall loses no word.
    push_valid = write_now;
    push_data = {eff, lane_mask(r.gw_n, r.bwe_n, r.bw_n), r.dq};
    pop_ready = !r.zz;
    if (buf_out_valid && pop_ready)
    begin
      for (int i = 0; i < sbs_pkg::LANES; i++)
      begin
        if (pop_lanes[i])
          next_r.mem[pop_addr][i*sbs_pkg::LANE_W +: sbs_pkg::LANE_W] =
            pop_word[i*sbs_pkg::LANE_W +: sbs_pkg::LANE_W];
      end
    end

    // A read that meets a queued write returns no data rather than stale data.
    // The host must leave one idle cycle after a write before a read, or the
    // lines stay undriven for that read.
    if (read_now && !buf_out_valid)
    begin
      for (int i = 0; i < sbs_pkg::LANES; i++)
      begin
        next_r.dout[i*sbs_pkg::BYTE_W +: 8] =
          r.mem[eff][i*sbs_pkg::LANE_W +: sbs_pkg::BYTE_W];
        next_r.pout[i] = r.mem[eff][i*sbs_pkg::LANE_W + sbs_pkg::LANE_PARITY_BIT];
      end
      next_r.have_data = 1'b1;
    end
    else if (read_now || write_now || deselect || r.zz)
    begin
      next_r.have_data = 1'b0;
    end

    // The deselect is decoded from the pins so the drivers let go at that edge.
    raw_deselect = starts_access(processor_address_strobe_n_in,
                                 controller_address_strobe_n_in,
                                 chip_select_primary_n_in) &&
                   !is_selected(chip_select_primary_n_in, chip_select_high_in,
                                chip_select_third_n_in);
    // Data of a new access from the deselected state exists only one edge
    // after its start, so the first cycle is always undriven.
    next_r.oe = next_r.have_data && !output_enable_n_in && !raw_deselect &&
                !sleep_request_in;
    // Ready reports room for one more write; with pushes and pops paired it
    // only drops for sleep or while reset is held.
    next_r.ready = buf_in_ready && !sleep_request_in;

    // Bypass scan path: sample on the rise, present on the fall.
    // The scan clock is seen only through samples on mclk_in, so it must
    // run far slower than mclk_in; each scan edge acts at the first mclk_in edge that samples it.
    next_r.tck = test_clk_in;
    if (test_clk_in && !r.tck)
    begin
      next_r.tdi_cap = test_data_in;
      next_r.tms_cap = test_mode_select_in;
    end
    if (!test_clk_in && r.tck)
    begin
      next_r.tdo = r.tdi_cap;
      next_r.tdo_oe = !r.tms_cap;
    end
  end

  always_ff @(posedge mclk_in)
  begin
    if (!rstn_in)
    begin
      // Sampled controls reset to their idle pin levels, so the first edge
      // after reset decodes neither a start nor a write.
      r <= '0;
      r.processor_address_strobe_n <= sbs_pkg::CTRL_IDLE_N;
      r.controller_address_strobe_n <= sbs_pkg::CTRL_IDLE_N;
      r.adv_n <= sbs_pkg::CTRL_IDLE_N;
      r.ce1_n <= sbs_pkg::CTRL_IDLE_N;
      r.ce3_n <= sbs_pkg::CTRL_IDLE_N;
      r.gw_n <= sbs_pkg::CTRL_IDLE_N;
      r.bwe_n <= sbs_pkg::CTRL_IDLE_N;
      r.bw_n <= sbs_pkg::LANE_IDLE_N;
      r.mode <= sbs_pkg::MODE_INTERLEAVED;
    end
    else
    begin
      r <= next_r;
    end
  end

  // Pushes and pops share the sleep gate, so at most one word waits here;
  // the second entry is headroom and no write is ever dropped.
  sbs_buffer #(
    .WIDTH(ENTRY_W),
    .DEPTH(sbs_pkg::WBUF_DEPTH)
  ) u_write_buffer (
    .mclk_in(mclk_in),
    .rstn_in(rstn_in),
    .in_valid_in(push_valid),
    .in_data_in(push_data),
    .in_ready_out(buf_in_ready),
    .out_valid_out(buf_out_valid),
    .out_data_out(buf_out_data),
    .out_ready_in(pop_ready)
  );

  // Outputs come straight from registers: the output register stage and the scan path.
  assign data_out = r.dout;
  assign parity_lines_out = r.pout;
  assign data_oe_out = r.oe;
  assign parity_lines_oe_out = r.oe;
  assign accept_ready_out = r.ready;
  assign test_data_out = r.tdo;
  assign test_data_oe_out = r.tdo_oe;

endmodule

// *** sbs_sram_monitor.sv ***
// Pin checker of the burst memory: decode, drive timing, sleep and scan.
// Assumes it is bound to sbs_sram and sees only its ports.
`timescale 1ns/1ns
module sbs_sram_monitor (
  // Clock and reset
  input wire logic mclk_in,
  input wire logic rstn_in,
  // Watched inputs
  input wire logic processor_address_strobe_n_in,
  input wire logic controller_address_strobe_n_in,
  input wire logic chip_select_primary_n_in,
  input wire logic chip_select_high_in,
  input wire logic chip_select_third_n_in,
  input wire logic global_write_n_in,
  input wire logic byte_write_gate_n_in,
  input wire logic output_enable_n_in,
  input wire logic sleep_request_in,
  input wire logic test_clk_in,
  // Watched outputs
  input wire logic accept_ready_out,
  input wire logic data_oe_out,
  input wire logic parity_lines_oe_out,
  input wire logic test_data_out
);
  default clocking mon_cb @(posedge mclk_in);
  endclocking
  default disable iff (!rstn_in);
  logic sel, go, wr, rd_go, desel, ctl_wr, calm;
  logic [2:0] quiet;
  assign sel = !chip_select_primary_n_in && chip_select_high_in && !chip_select_third_n_in;
  assign calm = processor_address_strobe_n_in && controller_address_strobe_n_in;
  assign go = !calm && (!chip_select_primary_n_in || !controller_address_strobe_n_in);
  assign wr = !global_write_n_in || !byte_write_gate_n_in;
  assign rd_go = go && sel && !wr;
  assign desel = go && !sel;
  assign ctl_wr = !controller_address_strobe_n_in && processor_address_strobe_n_in && sel && wr;
  // A write still in the buffer holds reads back, so latency is judged after a quiet spell.
  always_ff @(posedge mclk_in)
    if (!rstn_in || wr || sleep_request_in)
      quiet <= 3'h0;
    else if (quiet != 3'h7)
      quiet <= quiet + 3'h1;
  rd_lat_a: assert property (rd_go && quiet > 3'h4 && !sleep_request_in ##1
    (!output_enable_n_in && !sleep_request_in && !wr && !desel) |=> data_oe_out)
    else $error("read data not driven");
  oe_off_a: assert property (output_enable_n_in |=> !data_oe_out)
    else $error("lines driven with enable high");
  oe_pair_a: assert property (parity_lines_oe_out |->
    data_oe_out && $past(output_enable_n_in) == 1'b0)
    else $error("parity lines driven without enable");
  sleep_off_a: assert property (sleep_request_in |=> !data_oe_out && !accept_ready_out)
    else $error("activity during sleep");
  desel_off_a: assert property (desel |=> !data_oe_out)
    else $error("drive kept after deselect");
  first_cyc_a: assert property (desel ##1 rd_go |=> !data_oe_out)
    else $error("drive in first cycle after deselect");
  wr_off_a: assert property (ctl_wr ##1 calm |=> !data_oe_out)
    else $error("drive during write");
  scan_out_a: assert property ($changed(test_data_out) |-> !test_clk_in)
    else $error("scan output moved with test clock high");
  cover property (rd_go ##2 data_oe_out);
  cover property (desel ##1 rd_go);
  cover property ($rose(test_data_out));
endmodule

bind sbs_sram sbs_sram_monitor mon_u (.mclk_in(mclk_in), .rstn_in(rstn_in),
  .processor_address_strobe_n_in(processor_address_strobe_n_in),
  .controller_address_strobe_n_in(controller_address_strobe_n_in),
  .chip_select_primary_n_in(chip_select_primary_n_in),
  .chip_select_high_in(chip_select_high_in), .chip_select_third_n_in(chip_select_third_n_in),
  .global_write_n_in(global_write_n_in), .byte_write_gate_n_in(byte_write_gate_n_in),
  .output_enable_n_in(output_enable_n_in), .sleep_request_in(sleep_request_in),
  .test_clk_in(test_clk_in), .accept_ready_out(accept_ready_out), .data_oe_out(data_oe_out),
  .parity_lines_oe_out(parity_lines_oe_out), .test_data_out(test_data_out));
